// [acct_delay.sv]
// per-core trigger-to-conversion delay sequencer
`timescale 1ns/100ps
module acct_delay #(
   parameter int W = acct_pkg::CNT_W
) (
   input  wire logic         i_mclk,     // core clock
   input  wire logic         i_rstn,     // async reset, active low
   input  wire logic         i_trig,     // trigger pulse
   input  wire logic         i_en,       // delay feature enable
   input  wire logic [W-1:0] i_count,    // delay code
   output logic              o_sampling, // core is sampling
   output logic              o_conv      // conversion start pulse
);
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WAIT = 2'b10} acct_dly_e;
   acct_dly_e   st_q, st_d;
   logic [W:0]  cnt_q, cnt_d;
   logic        conv_d;

   // all-ones code is 1025 periods: code+1, plus one more at all ones
   function automatic logic [W:0] periods(input logic [W-1:0] c);
      periods = (&c) ? acct_pkg::CNT_MAX_PER : ({1'b0, c} + {{W{1'b0}}, 1'b1});
   endfunction : periods

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      conv_d = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (i_trig && i_en) begin
               st_d  = ST_WAIT;
               cnt_d = periods(i_count);
            end else if (i_trig) begin
               conv_d = 1'b1;
            end
         end
         ST_WAIT: begin
            cnt_d = cnt_q - {{W{1'b0}}, 1'b1};
            if (cnt_q == {{W{1'b0}}, 1'b1}) begin
               st_d   = ST_IDLE;
               conv_d = 1'b1;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q   <= ST_IDLE;
         cnt_q  <= '0;
         o_conv <= 1'b0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         o_conv <= conv_d;
      end
   end
   assign o_sampling = (st_q == ST_WAIT);

   a_delay_length: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (st_q == ST_IDLE && i_trig && i_en && i_count == '0)
      |=> o_sampling ##1 (!o_sampling && o_conv))
      else $error("delay of code zero not one period");
   a_no_delay: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (st_q == ST_IDLE && i_trig && !i_en) |=> o_conv && !o_sampling)
      else $error("disabled delay still delayed");
endmodule : acct_delay

// [acct_pkg.sv]
// constants and register map of the converter core timing control block
//----------------------------------------------------------------------
// Function
// - bit 15 of control-2-high is a read-only flag that follows band gap readiness.
// - bit 14 of control-2-high is a read-only flag set when the band gap is lost while the converter is on.
// - bits 9-0 of control-2-high hold the shared core sample count, all ones meaning 1025 core periods.
// - each of four dedicated cores has a 10-bit trigger-to-conversion delay, all ones meaning 1025 periods.
// - while a dedicated core's delay runs the core keeps sampling; conversion starts when it expires.
// - a dedicated core's delay applies only when its enable bit in control-4-low is set.
// - 22 early interrupt enables, bits 15-0 in the low register and 21-16 in the high register.
// - unimplemented bits of early-irq-enable-high and of the core delay registers read as zero.
//----------------------------------------------------------------------
package acct_pkg;
   localparam logic [11:0] OFS_CTRL2H    = 12'h000;
   localparam logic [11:0] OFS_CORE0     = 12'h004;
   localparam logic [11:0] OFS_CTRL4L    = 12'h014;
   localparam logic [11:0] OFS_EIE_LO    = 12'h018;
   localparam logic [11:0] OFS_EIE_HI    = 12'h01C;
   localparam logic [11:0] OFS_IRQ_STAT  = 12'h020;
   localparam logic [11:0] OFS_IRQ_MASK  = 12'h024;
   localparam int          BIT_REF_RDY   = 15;
   localparam int          BIT_REF_ERR   = 14;
   localparam int          CNT_W         = 10;
   localparam int          NUM_CORES     = 4;
   localparam int          NUM_CHAN      = 22;
   localparam int          EIE_LO_W      = 16;
   localparam int          IRQ_W         = 3;
   localparam logic [9:0]  CNT_RST       = 10'h000;
   localparam logic [9:0]  CNT_ALL_ONES  = 10'h3FF;
   localparam logic [10:0] CNT_MAX_PER   = 11'h401;
   // interrupt status bit positions
   localparam int          IRQ_RDY_RISE  = 0;
   localparam int          IRQ_REF_ERR   = 1;
   localparam int          IRQ_CONV      = 2;
endpackage : acct_pkg

// [acct_sync.sv]
// two flip-flop synchroniser for asynchronous status levels
`timescale 1ns/100ps
module acct_sync #(
   parameter int W = 1
) (
   input  wire logic         i_mclk,  // core clock
   input  wire logic         i_rstn,  // async reset, active low
   input  wire logic [W-1:0] i_d,     // async level
   output logic      [W-1:0] o_q      // synchronised level
);
   logic [W-1:0] meta_q;
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_q <= '0;
         o_q    <= '0;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule : acct_sync

// [acct_top.sv]
// register file and timing control of the converter cores, ahb-lite slave
`timescale 1ns/100ps
module acct_top #(
   parameter int NCORE = acct_pkg::NUM_CORES,
   parameter int NCHAN = acct_pkg::NUM_CHAN
) (
   input  wire logic             i_mclk,        // core clock 100 MHz
   input  wire logic             i_rstn,        // async reset, active low
   input  wire logic             i_hsel,        // slave select
   input  wire logic [11:0]      i_haddr,       // byte address
   input  wire logic [1:0]       i_htrans,      // transfer type
   input  wire logic             i_hwrite,      // write strobe
   input  wire logic [2:0]       i_hsize,       // transfer size
   input  wire logic [31:0]      i_hwdata,      // write data
   input  wire logic             i_hready,      // bus ready
   output logic      [31:0]      o_hrdata,      // read data
   output logic                  o_hreadyout,   // slave ready
   output logic                  o_hresp,       // always okay
   input  wire logic             i_bandgap_ok,  // async band gap ready level
   input  wire logic             i_conv_on,     // converter switched on
   input  wire logic [NCORE-1:0] i_core_trig,   // per-core trigger pulse
   output logic      [NCORE-1:0] o_core_sample, // core is sampling
   output logic      [NCORE-1:0] o_core_conv,   // conversion start pulse
   output logic      [9:0]       o_shared_dedicated_core_delay_count, // shared core sample count
   output logic      [NCHAN-1:0] o_early_en,    // early irq channel enables
   output logic                  o_irq          // level interrupt
);
   //------------------------------------------------------------------
   // registers
   //------------------------------------------------------------------
   logic [9:0]             shr_q, shr_d;
   logic [9:0]             core_q [NCORE];
   logic [9:0]             core_d [NCORE];
   logic [NCORE-1:0]       dly_en_q, dly_en_d;
   logic [NCHAN-1:0]       eie_q, eie_d;
   logic                   rdy_q, rdy_d;
   logic                   err_q, err_d;
   logic [2:0]             stat_q, stat_d;
   logic [2:0]             mask_q, mask_d;
   logic                   wr_pend_q, wr_pend_d;
   logic [11:0]            wr_addr_q, wr_addr_d;
   logic [31:0]            rdata_d;
   logic                   irq_d;
   logic                   bg_sync;
   logic [NCORE-1:0]       samp_w, conv_w;
   logic                   conv_any;

   acct_sync #(.W(1)) u_sync (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .i_d    (i_bandgap_ok),
      .o_q    (bg_sync)
   );

   //------------------------------------------------------------------
   // dedicated core delay sequencers
   //------------------------------------------------------------------
   for (genvar g = 0; g < NCORE; g++) begin : g_core
      acct_delay #(.W(acct_pkg::CNT_W)) u_dly (
         .i_mclk     (i_mclk),
         .i_rstn     (i_rstn),
         .i_trig     (i_core_trig[g]),
         .i_en       (dly_en_q[g]),
         .i_count    (core_q[g]),
         .o_sampling (samp_w[g]),
         .o_conv     (conv_w[g])
      );
   end
   assign conv_any = |conv_w;

   function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
      addr_hit = (a[11:2] == ofs[11:2]);
   endfunction : addr_hit

   //------------------------------------------------------------------
   // bus, register and status next state
   //------------------------------------------------------------------
   logic addr_ph;
   logic [2:0] w1c;
   assign addr_ph = i_hsel && i_hready && i_htrans[1];

   always_comb begin
      shr_d     = shr_q;
      core_d    = core_q;
      dly_en_d  = dly_en_q;
      eie_d     = eie_q;
      mask_d    = mask_q;
      wr_pend_d = addr_ph && i_hwrite;
      wr_addr_d = addr_ph ? i_haddr : wr_addr_q;
      w1c       = 3'h0;
      rdata_d   = 32'h0000_0000;
      if (wr_pend_q) begin
         if (addr_hit(wr_addr_q, acct_pkg::OFS_CTRL2H))
            shr_d = i_hwdata[9:0];
         for (int i = 0; i < NCORE; i++) begin
            if (addr_hit(wr_addr_q, acct_pkg::OFS_CORE0 + 12'(4 * i)))
               core_d[i] = i_hwdata[9:0];
         end
         if (addr_hit(wr_addr_q, acct_pkg::OFS_CTRL4L))
            dly_en_d = i_hwdata[NCORE-1:0];
         if (addr_hit(wr_addr_q, acct_pkg::OFS_EIE_LO))
            eie_d[15:0] = i_hwdata[15:0];
         if (addr_hit(wr_addr_q, acct_pkg::OFS_EIE_HI))
            eie_d[NCHAN-1:16] = i_hwdata[NCHAN-17:0];
         if (addr_hit(wr_addr_q, acct_pkg::OFS_IRQ_MASK))
            mask_d = i_hwdata[2:0];
         if (addr_hit(wr_addr_q, acct_pkg::OFS_IRQ_STAT))
            w1c = i_hwdata[2:0];
      end
      // reads: reserved and unimplemented bits stay zero
      if (addr_ph && !i_hwrite) begin
         if (addr_hit(i_haddr, acct_pkg::OFS_CTRL2H))
            rdata_d = {16'h0000, rdy_q, err_q, 4'h0, shr_q};
         for (int i = 0; i < NCORE; i++) begin
            if (addr_hit(i_haddr, acct_pkg::OFS_CORE0 + 12'(4 * i)))
               rdata_d = {22'h00_0000, core_q[i]};
         end
         if (addr_hit(i_haddr, acct_pkg::OFS_CTRL4L))
            rdata_d = {28'h000_0000, dly_en_q};
         if (addr_hit(i_haddr, acct_pkg::OFS_EIE_LO))
            rdata_d = {16'h0000, eie_q[15:0]};
         if (addr_hit(i_haddr, acct_pkg::OFS_EIE_HI))
            rdata_d = {26'h000_0000, eie_q[NCHAN-1:16]};
         if (addr_hit(i_haddr, acct_pkg::OFS_IRQ_STAT))
            rdata_d = {29'h0000_0000, stat_q};
         if (addr_hit(i_haddr, acct_pkg::OFS_IRQ_MASK))
            rdata_d = {29'h0000_0000, mask_q};
      end
      rdy_d = bg_sync;
      // loss while on latches; cleared only when the converter is off
      err_d = (err_q && i_conv_on) || (rdy_q && !bg_sync && i_conv_on);
      // set wins over a write-one clear in the same cycle
      stat_d = (stat_q & ~w1c)
             | {conv_any, (!err_q && err_d), (!rdy_q && rdy_d)};
      irq_d  = |(stat_d & mask_d);
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         shr_q     <= acct_pkg::CNT_RST;
         for (int i = 0; i < NCORE; i++) core_q[i] <= acct_pkg::CNT_RST;
         dly_en_q  <= '0;
         eie_q     <= '0;
         rdy_q     <= 1'b0;
         err_q     <= 1'b0;
         stat_q    <= 3'h0;
         mask_q    <= 3'h0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
         o_hrdata  <= 32'h0000_0000;
         o_irq     <= 1'b0;
      end else begin
         shr_q     <= shr_d;
         core_q    <= core_d;
         dly_en_q  <= dly_en_d;
         eie_q     <= eie_d;
         rdy_q     <= rdy_d;
         err_q     <= err_d;
         stat_q    <= stat_d;
         mask_q    <= mask_d;
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         o_hrdata  <= rdata_d;
         o_irq     <= irq_d;
      end
   end

   // zero wait states keeps o_hreadyout and o_hresp constant; still flops per house style, like the other outputs here
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_hreadyout   <= 1'b1;
         o_hresp       <= 1'b0;
         o_core_sample <= '0;
         o_core_conv   <= '0;
         o_shared_dedicated_core_delay_count <= 10'h000;
         o_early_en    <= '0;
      end else begin
         o_hreadyout   <= 1'b1;
         o_hresp       <= 1'b0;
         o_core_sample <= samp_w;
         o_core_conv   <= conv_w;
         o_shared_dedicated_core_delay_count <= shr_q;
         o_early_en    <= eie_q;
      end
   end

   //------------------------------------------------------------------
   // checks
   //------------------------------------------------------------------
   a_rdy_follows: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      ##1 rdy_q == $past(bg_sync))
      else $error("ready flag does not follow band gap");
   a_err_on_loss: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (rdy_q && !bg_sync && i_conv_on) |=> err_q)
      else $error("band gap loss not flagged");
   a_err_quiet: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (!err_q && !(rdy_q && !bg_sync)) |=> !err_q)
      else $error("error flag set without loss");
   a_shr_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (wr_pend_q && wr_addr_q[11:2] == 10'h000)
      |=> ##1 o_shared_dedicated_core_delay_count == $past(i_hwdata[9:0], 2))
      else $error("shared sample count not written");
   a_eie_hi_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (addr_ph && !i_hwrite && i_haddr[11:2] == 10'h007) |=> o_hrdata[31:6] == 26'h0)
      else $error("unimplemented bits read non zero");
   a_eie_out: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      ##1 o_early_en == $past(eie_q))
      else $error("early enables out of step");
   a_samp_conv: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      $fell(o_core_sample[0]) |-> o_core_conv[0])
      else $error("sampling ended without conversion");
   // the level must match the registered status and mask, not the next state
   a_irq_level: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      o_irq == |(stat_q & mask_q))
      else $error("interrupt level wrong");
   c_loss: cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(err_q));
   c_delay: cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(o_core_sample[0]));
   c_irq: cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(o_irq));
endmodule : acct_top

// [acct_top_tb_top.sv]
// self-checking testbench of the converter core timing control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module acct_top_tb_top;
   logic        i_mclk = 1'b0;
   logic        i_rstn = 1'b0;
   logic        i_hsel = 1'b0;
   logic [11:0] i_haddr = 12'h000;
   logic [1:0]  i_htrans = 2'h0;
   logic        i_hwrite = 1'b0;
   logic [31:0] i_hwdata = 32'h0;
   logic        i_bandgap_ok = 1'b0;
   logic        i_conv_on = 1'b0;
   logic [3:0]  i_core_trig = 4'h0;
   logic [31:0] o_hrdata;
   logic        o_hreadyout;
   logic        o_hresp;
   logic        o_irq;
   logic [3:0]  o_core_sample;
   logic [3:0]  o_core_conv;
   logic [9:0]  o_shared_dedicated_core_delay_count;
   logic [21:0] o_early_en;
   logic        rd_phase = 1'b0;
   logic [31:0] exp_q[$];
   string       nm_q[$];
   logic [31:0] m_e;
   string       m_n;
   int          n_mismatch = 0;
   int          checked = 0;
   integer      seed = 49;

   acct_top acct_top_inst (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
      .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
      .o_hresp(o_hresp), .i_bandgap_ok(i_bandgap_ok), .i_conv_on(i_conv_on),
      .i_core_trig(i_core_trig), .o_core_sample(o_core_sample), .o_core_conv(o_core_conv),
      .o_shared_dedicated_core_delay_count(o_shared_dedicated_core_delay_count), .o_early_en(o_early_en), .o_irq(o_irq));

   initial begin
      forever #5 i_mclk = ~i_mclk;
   end

   //----------------------------------------------------------------------
   // read data monitor: pairs each data phase with the oldest note
   //----------------------------------------------------------------------
   always @(posedge i_mclk) begin
      if (rd_phase) begin
         m_e = exp_q.pop_front();
         m_n = nm_q.pop_front();
         `CHK(m_n, m_e, o_hrdata)
         `CHK("hresp", 1'b0, o_hresp)
      end
   end

   //----------------------------------------------------------------------
   // bus master and helpers, entered just after a rising edge
   //----------------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : cyc

   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      i_hsel   <= 1'b1;
      i_haddr  <= a;
      i_htrans <= 2'h2;
      i_hwrite <= w;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      i_hsel   <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      rd_phase <= !w;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      rd_phase <= 1'b0;
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      exp_q.push_back(e);
      nm_q.push_back(nm);
      bus(a, 1'b0, 32'h0);
   endtask : rd

   function automatic int span(input logic [9:0] c);
      return (c == 10'h3FF) ? 1025 : int'(c) + 1;
   endfunction : span

   // counts sampling cycles between a trigger and its conversion pulse
   task automatic fire(input int k, input int exp_n);
      int n;
      int t;
      n = 0;
      i_core_trig[k] <= 1'b1;
      @(posedge i_mclk);
      i_core_trig[k] <= 1'b0;
      for (t = 0; t < 1200 && o_core_conv[k] !== 1'b1; t++) begin
         @(posedge i_mclk);
         #1;
         if (o_core_sample[k] === 1'b1) n++;
      end
      `CHK("conv_start", 4'(1 << k), o_core_conv)
      `CHK("sample_len", exp_n, n)
      @(posedge i_mclk);
      #1;
      `CHK("conv_pulse", 4'h0, o_core_conv)
      @(posedge i_mclk);
   endtask : fire

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   //----------------------------------------------------------------------
   // scenarios
   //----------------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [31:0] r2;
      logic [31:0] d;
      logic [9:0]  codes[4];
      repeat (12) @(posedge i_mclk);
      i_rstn <= 1'b1;
      @(posedge i_mclk);
      for (int a = 0; a < 12'h030; a += 4) rd(12'(a), 32'h0, "reset_value");
      wr(12'h030, 32'hFFFF_FFFF);
      rd(12'h030, 32'h0, "unmapped");
      `CHK("irq_reset", 1'b0, o_irq)
      $display("test reset_values done");
      wr(acct_pkg::OFS_IRQ_MASK, 32'h7);
      i_conv_on    <= 1'b1;
      i_bandgap_ok <= 1'b1;
      cyc(6);
      rd(acct_pkg::OFS_CTRL2H, 32'h8000, "ready_flag");
      rd(acct_pkg::OFS_IRQ_STAT, 32'h1, "stat_ready");
      `CHK("irq_ready", 1'b1, o_irq)
      i_bandgap_ok <= 1'b0;
      cyc(6);
      rd(acct_pkg::OFS_CTRL2H, 32'h4000, "error_flag");
      rd(acct_pkg::OFS_IRQ_STAT, 32'h3, "stat_error");
      wr(acct_pkg::OFS_IRQ_STAT, 32'h3);
      cyc(2);
      rd(acct_pkg::OFS_IRQ_STAT, 32'h0, "stat_cleared");
      `CHK("irq_cleared", 1'b0, o_irq)
      wr(acct_pkg::OFS_IRQ_MASK, 32'h0);
      i_bandgap_ok <= 1'b1;
      cyc(6);
      rd(acct_pkg::OFS_IRQ_STAT, 32'h1, "stat_masked");
      `CHK("irq_masked", 1'b0, o_irq)
      wr(acct_pkg::OFS_IRQ_STAT, 32'h1);
      i_conv_on <= 1'b0;
      cyc(2);
      rd(acct_pkg::OFS_CTRL2H, 32'h8000, "error_gone");
      $display("test reference_flags done");
      // reserved bits kept at zero, read-only flags written as ones
      wr(acct_pkg::OFS_CTRL2H, 32'h0000_C3FF);
      rd(acct_pkg::OFS_CTRL2H, 32'h0000_83FF, "shared_count");
      `CHK("shared_out", 10'h3FF, o_shared_dedicated_core_delay_count)
      r = $random(seed);
      r2 = $random(seed);
      wr(acct_pkg::OFS_EIE_LO, r);
      wr(acct_pkg::OFS_EIE_HI, r2);
      rd(acct_pkg::OFS_EIE_LO, r & 32'h0000_FFFF, "eie_low");
      rd(acct_pkg::OFS_EIE_HI, r2 & 32'h0000_003F, "eie_high");
      `CHK("eie_out", {r2[5:0], r[15:0]}, o_early_en)
      wr(acct_pkg::OFS_CTRL4L, 32'hFFFF_FFFF);
      rd(acct_pkg::OFS_CTRL4L, 32'h0000_000F, "delay_enables");
      $display("test register_fields done");
      codes = '{10'h000, 10'h3FF, 10'h005, r[25:16]};
      for (int k = 0; k < 4; k++) begin
         d = $random(seed);
         d[9:0] = codes[k];
         wr(acct_pkg::OFS_CORE0 + 12'(4 * k), d);
         rd(acct_pkg::OFS_CORE0 + 12'(4 * k), {22'h0, codes[k]}, "core_delay");
         fire(k, span(codes[k]));
      end
      wr(acct_pkg::OFS_CTRL4L, 32'h0);
      fire(2, 0);
      rd(acct_pkg::OFS_IRQ_STAT, 32'h4, "stat_conv");
      wr(acct_pkg::OFS_IRQ_MASK, 32'h4);
      cyc(2);
      `CHK("irq_conv", 1'b1, o_irq)
      wr(acct_pkg::OFS_IRQ_STAT, 32'h4);
      cyc(2);
      `CHK("irq_conv_clr", 1'b0, o_irq)
      $display("test core_delays done");
      end_sim();
   end

   initial begin
      #100us;
      n_mismatch++;
      $display("watchdog expired");
      end_sim();
   end
endmodule : acct_top_tb_top
